// [inc/wid_pkg.sv]
// Function
// - Wake-up only leaves sleep or idle; in green and normal modes sources act only as interrupts.
// - Sources are external pin, pin change, timer overflow, conversion done, comparator, PWM and low-voltage events, each gated by its own enables.
// - In sleep, an enabled external-pin wake with interrupts disabled resumes at the next instruction.
// - In idle, an enabled external-pin wake with interrupts disabled resumes at the next instruction.
// - In sleep, pin change with wake and interrupt enables set and interrupts enabled branches to the vector.
// - In sleep or idle, pin change wake with interrupts disabled resumes at the next instruction.
// - A vectored wake uses the source vector: 0x06 pin change, 0x0f comparator, 0x0c conversion, 0x21 low voltage.
// - Entering sleep stops oscillator and timers unless a conversion is running; an enabled watchdog is cleared and keeps running.
package wid_pkg;

  localparam int NSRC = 10;

  // Source indices, lowest index has priority
  localparam int SRC_EXT     = 0;
  localparam int SRC_PCHG    = 1;
  localparam int SRC_TIMER   = 2;
  localparam int SRC_CONV    = 3;
  localparam int SRC_CMP     = 4;
  localparam int SRC_PWMA_P  = 5;
  localparam int SRC_PWMB_P  = 6;
  localparam int SRC_PWMA_D  = 7;
  localparam int SRC_PWMB_D  = 8;
  localparam int SRC_LVD     = 9;

  // Sources able to wake from sleep by their wake enable
  localparam logic [NSRC-1:0] SLEEP_WAKE_SET = 10'h21b;
  // Sources whose interrupt enable alone wakes from idle
  localparam logic [NSRC-1:0] IDLE_IRQ_WAKE_SET = 10'h1e4;

  typedef logic [7:0] wid_vec_t;
  localparam wid_vec_t VEC_EXT    = 8'h03;
  localparam wid_vec_t VEC_PCHG   = 8'h06;
  localparam wid_vec_t VEC_TIMER  = 8'h09;
  localparam wid_vec_t VEC_CONV   = 8'h0c;
  localparam wid_vec_t VEC_CMP    = 8'h0f;
  localparam wid_vec_t VEC_PWMA_P = 8'h12;
  localparam wid_vec_t VEC_PWMB_P = 8'h15;
  localparam wid_vec_t VEC_PWMA_D = 8'h18;
  localparam wid_vec_t VEC_PWMB_D = 8'h1b;
  localparam wid_vec_t VEC_LVD    = 8'h21;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_WAKE_EN  = 8'h04;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h08;
  localparam logic [7:0] OFS_STATE    = 8'h0c;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam logic [7:0] OFS_LAST_VEC = 8'h18;

  // Control bits
  localparam int CTRL_IDLE_SEL  = 0;
  localparam int CTRL_GREEN_SEL = 1;
  localparam int CTRL_WDT_EN    = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [NSRC-1:0] EN_RST = 10'h000;

  // Interrupt status bits
  localparam int NINT        = 4;
  localparam int INT_WAKE    = 0;
  localparam int INT_VECTOR  = 1;
  localparam int INT_SLEEP   = 2;
  localparam int INT_CFG_ERR = 3;
  localparam logic [NINT-1:0] INT_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    WID_NORMAL = 4'b0001,
    WID_GREEN  = 4'b0010,
    WID_IDLE   = 4'b0100,
    WID_SLEEP  = 4'b1000
  } wid_mode_e;

endpackage

// [src/wid_axil_slave.sv]
`timescale 1ns/1ps
module wid_axil_slave (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register side
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_q;
  logic [31:0] w_q;
  logic [3:0]  s_q;
  logic        aw_have;
  logic        w_have;

  assign awready = !aw_hold && !bvalid;
  assign wready  = !w_hold && !bvalid;
  assign arready = !rvalid;
  assign aw_have = aw_hold || (awvalid && awready);
  assign w_have  = w_hold || (wvalid && wready);
  assign wr_en   = aw_have && w_have && !bvalid;
  assign wr_addr = aw_hold ? aw_q : awaddr;
  assign wr_data = w_hold ? w_q : wdata;
  assign wr_strb = w_hold ? s_q : wstrb;
  assign rd_addr = araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      aw_q    <= 8'h00;
    end else if (wr_en) begin
      aw_hold <= 1'b0;
    end else if (awvalid && awready) begin
      aw_hold <= 1'b1;
      aw_q    <= awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold <= 1'b0;
      w_q    <= 32'h0000_0000;
      s_q    <= 4'h0;
    end else if (wr_en) begin
      w_hold <= 1'b0;
    end else if (wvalid && wready) begin
      w_hold <= 1'b1;
      w_q    <= wdata;
      s_q    <= wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= wid_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? wid_pkg::RESP_OKAY : wid_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= wid_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_ok ? rd_data : 32'h0000_0000;
      rresp  <= rd_ok ? wid_pkg::RESP_OKAY : wid_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// [src/wid_dispatch.sv]
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module wid_dispatch (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // AXI4-Lite register bus
  input  wire logic [7:0]               s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [7:0]               s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // Instruction core
  input  wire logic                     global_irq_enable_instr,
  input  wire logic                     global_irq_disable_instr,
  input  wire logic                     sleep_instr,
  output logic                          core_halted,
  output logic                          wake_pulse,
  output logic                          vector_take,
  output logic [7:0]                    vector_addr,
  // Peripheral events
  input  wire logic [wid_pkg::NSRC-1:0] src_event,
  input  wire logic                     conv_busy,
  // Clock and watchdog control
  output logic                          osc_run,
  output logic                          timers_run,
  output logic                          wdt_clear,
  // Interrupt
  output logic                          irq
);
  wid_pkg::wid_mode_e       mode;
  wid_pkg::wid_mode_e       next_mode;
  logic                     gie;
  logic [2:0]               ctrl;
  logic [wid_pkg::NSRC-1:0] wake_en;
  logic [wid_pkg::NSRC-1:0] irq_en;
  logic [wid_pkg::NINT-1:0] int_stat;
  logic [wid_pkg::NINT-1:0] int_mask;
  logic [wid_pkg::NINT-1:0] int_set;
  logic [7:0]               last_vec;
  logic                     wr_en;
  logic [7:0]               wr_addr;
  logic [31:0]              wr_data;
  logic [3:0]               wr_strb;
  logic [31:0]              wmask;
  logic                     wr_ok;
  logic [7:0]               rd_addr;
  logic [31:0]              rd_data;
  logic                     rd_ok;
  logic [wid_pkg::NSRC-1:0] can_wake;
  logic [wid_pkg::NSRC-1:0] can_irq;
  logic [wid_pkg::NSRC-1:0] hit;
  logic [7:0]               vec_tab [wid_pkg::NSRC];
  logic                     asleep;
  logic                     any_hit;
  logic                     do_vector;
  logic [7:0]               sel_vec;
  logic                     multi_wake;
  logic                     enter_sleep;

  wid_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  assign wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

  always_comb begin
    wr_ok = 1'b1;
    case (wr_addr)
      wid_pkg::OFS_CTRL,
      wid_pkg::OFS_WAKE_EN,
      wid_pkg::OFS_IRQ_EN,
      wid_pkg::OFS_INT_STAT,
      wid_pkg::OFS_INT_MASK: wr_ok = 1'b1;
      wid_pkg::OFS_STATE,
      wid_pkg::OFS_LAST_VEC: wr_ok = 1'b1;
      default:               wr_ok = 1'b0;
    endcase
  end

  // Vector table per source
  assign vec_tab[wid_pkg::SRC_EXT]    = wid_pkg::VEC_EXT;
  assign vec_tab[wid_pkg::SRC_PCHG]   = wid_pkg::VEC_PCHG;
  assign vec_tab[wid_pkg::SRC_TIMER]  = wid_pkg::VEC_TIMER;
  assign vec_tab[wid_pkg::SRC_CONV]   = wid_pkg::VEC_CONV;
  assign vec_tab[wid_pkg::SRC_CMP]    = wid_pkg::VEC_CMP;
  assign vec_tab[wid_pkg::SRC_PWMA_P] = wid_pkg::VEC_PWMA_P;
  assign vec_tab[wid_pkg::SRC_PWMB_P] = wid_pkg::VEC_PWMB_P;
  assign vec_tab[wid_pkg::SRC_PWMA_D] = wid_pkg::VEC_PWMA_D;
  assign vec_tab[wid_pkg::SRC_PWMB_D] = wid_pkg::VEC_PWMB_D;
  assign vec_tab[wid_pkg::SRC_LVD]    = wid_pkg::VEC_LVD;

  assign asleep = (mode == wid_pkg::WID_SLEEP) || (mode == wid_pkg::WID_IDLE);

  // Per-source gating by mode and enables
  for (genvar i = 0; i < wid_pkg::NSRC; i++) begin : g_src
    always_comb begin
      case (mode)
        wid_pkg::WID_SLEEP: can_wake[i] = wid_pkg::SLEEP_WAKE_SET[i] && wake_en[i];
        wid_pkg::WID_IDLE:  can_wake[i] = (wid_pkg::SLEEP_WAKE_SET[i] && wake_en[i]) ||
                                          (wid_pkg::IDLE_IRQ_WAKE_SET[i] && irq_en[i]);
        default:            can_wake[i] = 1'b0;
      endcase
    end
    assign can_irq[i] = irq_en[i];
    assign hit[i]     = src_event[i] && (asleep ? can_wake[i] : can_irq[i]);
  end

  assign any_hit = |hit;

  // Lowest index wins when events coincide
  always_comb begin
    sel_vec   = vec_tab[0];
    do_vector = 1'b0;
    for (int k = wid_pkg::NSRC - 1; k >= 0; k--) begin
      if (hit[k]) begin
        sel_vec   = vec_tab[k];
        do_vector = gie && irq_en[k];
      end
    end
  end

  // Enabled wake sources in excess of one, or watchdog plus any
  always_comb begin
    int n;
    n = 0;
    for (int k = 0; k < wid_pkg::NSRC; k++) begin
      if (wid_pkg::SLEEP_WAKE_SET[k] && wake_en[k]) begin
        n = n + 1;
      end
    end
    multi_wake = (n > 1) || ((n > 0) && ctrl[wid_pkg::CTRL_WDT_EN]);
  end

  assign enter_sleep = sleep_instr && !asleep;

  always_comb begin
    next_mode = mode;
    case (mode)
      wid_pkg::WID_NORMAL,
      wid_pkg::WID_GREEN: begin
        if (enter_sleep) begin
          next_mode = ctrl[wid_pkg::CTRL_IDLE_SEL] ? wid_pkg::WID_IDLE : wid_pkg::WID_SLEEP;
        end else begin
          next_mode = ctrl[wid_pkg::CTRL_GREEN_SEL] ? wid_pkg::WID_GREEN : wid_pkg::WID_NORMAL;
        end
      end
      wid_pkg::WID_IDLE,
      wid_pkg::WID_SLEEP: begin
        if (any_hit) begin
          next_mode = ctrl[wid_pkg::CTRL_GREEN_SEL] ? wid_pkg::WID_GREEN : wid_pkg::WID_NORMAL;
        end
      end
      default: next_mode = wid_pkg::WID_NORMAL;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= wid_pkg::WID_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie <= 1'b0;
    end else if (global_irq_enable_instr) begin
      gie <= 1'b1;
    end else if (global_irq_disable_instr) begin
      gie <= 1'b0;
    end
  end

  // Dispatch outcome to the core
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_pulse  <= 1'b0;
      vector_take <= 1'b0;
      vector_addr <= 8'h00;
      last_vec    <= 8'h00;
    end else begin
      wake_pulse  <= asleep && any_hit;
      vector_take <= any_hit && do_vector;
      if (any_hit && do_vector) begin
        vector_addr <= sel_vec;
        last_vec    <= sel_vec;
      end
    end
  end

  // Sleep stops clocks unless a conversion is running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_run    <= 1'b1;
      timers_run <= 1'b1;
      wdt_clear  <= 1'b0;
    end else begin
      osc_run    <= !(next_mode == wid_pkg::WID_SLEEP) || conv_busy;
      timers_run <= !(next_mode == wid_pkg::WID_SLEEP) || conv_busy;
      wdt_clear  <= enter_sleep && ctrl[wid_pkg::CTRL_WDT_EN];
    end
  end

  assign core_halted = asleep;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= wid_pkg::CTRL_RST;
    end else if (wr_en && wr_addr == wid_pkg::OFS_CTRL) begin
      ctrl <= (ctrl & ~wmask[2:0]) | (wr_data[2:0] & wmask[2:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_en <= wid_pkg::EN_RST;
    end else if (wr_en && wr_addr == wid_pkg::OFS_WAKE_EN) begin
      wake_en <= (wake_en & ~wmask[9:0]) | (wr_data[9:0] & wmask[9:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en <= wid_pkg::EN_RST;
    end else if (wr_en && wr_addr == wid_pkg::OFS_IRQ_EN) begin
      irq_en <= (irq_en & ~wmask[9:0]) | (wr_data[9:0] & wmask[9:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_mask <= wid_pkg::INT_RST;
    end else if (wr_en && wr_addr == wid_pkg::OFS_INT_MASK) begin
      int_mask <= (int_mask & ~wmask[3:0]) | (wr_data[3:0] & wmask[3:0]);
    end
  end

  assign int_set[wid_pkg::INT_WAKE]    = asleep && any_hit;
  assign int_set[wid_pkg::INT_VECTOR]  = any_hit && do_vector;
  assign int_set[wid_pkg::INT_SLEEP]   = enter_sleep;
  assign int_set[wid_pkg::INT_CFG_ERR] = enter_sleep && multi_wake;

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat <= wid_pkg::INT_RST;
    end else if (wr_en && wr_addr == wid_pkg::OFS_INT_STAT) begin
      int_stat <= (int_stat & ~(wr_data[3:0] & wmask[3:0])) | int_set;
    end else begin
      int_stat <= int_stat | int_set;
    end
  end

  assign irq = |(int_stat & int_mask);

  always_comb begin
    rd_ok   = 1'b1;
    rd_data = 32'h0000_0000;
    case (rd_addr)
      wid_pkg::OFS_CTRL:     rd_data[2:0] = ctrl;
      wid_pkg::OFS_WAKE_EN:  rd_data[9:0] = wake_en;
      wid_pkg::OFS_IRQ_EN:   rd_data[9:0] = irq_en;
      wid_pkg::OFS_STATE:    rd_data[5:0] = {multi_wake, gie, mode};
      wid_pkg::OFS_INT_STAT: rd_data[3:0] = int_stat;
      wid_pkg::OFS_INT_MASK: rd_data[3:0] = int_mask;
      wid_pkg::OFS_LAST_VEC: rd_data[7:0] = last_vec;
      default:               rd_ok = 1'b0;
    endcase
  end
endmodule

// [tb/wid_dispatch_chk.sv]
`timescale 1ns/1ps
module wid_dispatch_chk (
  // Clock and reset
  input wire logic                     aclk,
  input wire logic                     aresetn,
  // Core side
  input wire logic                     global_irq_enable_instr,
  input wire logic                     global_irq_disable_instr,
  input wire logic                     sleep_instr,
  input wire logic                     core_halted,
  input wire logic                     wake_pulse,
  input wire logic                     vector_take,
  input wire logic [7:0]               vector_addr,
  // Events and clock control
  input wire logic [wid_pkg::NSRC-1:0] src_event,
  input wire logic                     conv_busy,
  input wire logic                     osc_run,
  input wire logic                     timers_run,
  input wire logic                     wdt_clear
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wake_halt_a: assert property (wake_pulse |-> $past(core_halted))
    else $error("wake pulse outside halt");
  wake_resume_a: assert property (wake_pulse |-> !core_halted && osc_run)
    else $error("still halted after wake");
  wake_single_a: assert property (wake_pulse |=> !wake_pulse)
    else $error("wake pulse too long");
  vec_cause_a: assert property (vector_take |-> $past(src_event) != '0)
    else $error("vector without event");
  vec_pchg_a: assert property (vector_take && $past(src_event) == 10'h002 |-> vector_addr == 8'h06)
    else $error("pin change vector wrong");
  vec_conv_a: assert property (vector_take && $past(src_event) == 10'h008 |-> vector_addr == 8'h0c)
    else $error("conversion vector wrong");
  gie_off_a: assert property ($past(global_irq_disable_instr) && !$past(global_irq_enable_instr)
    |=> !vector_take)
    else $error("vector with interrupts disabled");
  sleep_enter_a: assert property (sleep_instr && !core_halted |=> core_halted)
    else $error("sleep not entered");
  wdt_cause_a: assert property (wdt_clear |-> $past(sleep_instr) && !$past(core_halted))
    else $error("watchdog clear without sleep");
  osc_halt_a: assert property (!osc_run |-> core_halted && !timers_run)
    else $error("clocks stopped while awake");
  busy_osc_a: assert property ($past(conv_busy) |-> osc_run)
    else $error("clock stopped during conversion");
endmodule

bind wid_dispatch wid_dispatch_chk u_wid_dispatch_chk (.aclk(aclk), .aresetn(aresetn),
  .global_irq_enable_instr(global_irq_enable_instr), .sleep_instr(sleep_instr),
  .global_irq_disable_instr(global_irq_disable_instr), .core_halted(core_halted),
  .wake_pulse(wake_pulse), .vector_take(vector_take), .vector_addr(vector_addr),
  .src_event(src_event), .conv_busy(conv_busy), .osc_run(osc_run),
  .timers_run(timers_run), .wdt_clear(wdt_clear));

// [tb/wid_core_model.sv]
`timescale 1ns/1ps
module wid_core_model (
  // Clock
  input  wire logic                     aclk,
  // Requests
  output logic                          global_irq_enable_instr,
  output logic                          global_irq_disable_instr,
  output logic                          sleep_instr,
  output logic [wid_pkg::NSRC-1:0]      src_event,
  // Answers
  input  wire logic                     wake_pulse,
  input  wire logic                     vector_take,
  input  wire logic [7:0]               vector_addr,
  input  wire logic                     osc_run,
  input  wire logic                     wdt_clear
);
  logic       got_wake;
  logic       got_vec;
  logic [7:0] got_addr;
  logic       got_osc;
  logic       got_wdt;

  initial begin
    {global_irq_enable_instr, global_irq_disable_instr, sleep_instr} = 3'h0;
    src_event = '0;
  end

  // One-cycle instruction: 0 enable, 1 disable, 2 sleep
  task automatic instr(input int k);
    @(posedge aclk);
    global_irq_enable_instr <= (k == 0);
    global_irq_disable_instr <= (k == 1);
    sleep_instr <= (k == 2);
    @(posedge aclk);
    {global_irq_enable_instr, global_irq_disable_instr, sleep_instr} <= 3'h0;
    #1;
    got_osc = osc_run;
    got_wdt = wdt_clear;
  endtask

  // One-cycle event from a single source
  task automatic fire(input int i);
    @(posedge aclk);
    src_event <= 10'h001 << i;
    @(posedge aclk);
    src_event <= 10'h000;
    #1;
    got_wake = wake_pulse;
    got_vec = vector_take;
    got_addr = vector_addr;
  endtask
endmodule

// [tb/wid_dispatch_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module wid_dispatch_tb;
  localparam logic [9:0] SLP_SET = 10'h21b;
  localparam logic [9:0] IDL_SET = 10'h1e4;
  localparam logic [7:0] VEC_TAB [10] = '{8'h03, 8'h06, 8'h09, 8'h0c, 8'h0f,
                                          8'h12, 8'h15, 8'h18, 8'h1b, 8'h21};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        conv_busy = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        gen, gdis, slp, halted, wake, vtake, osc, tmr, wdt, irq;
  logic [7:0]  vaddr;
  logic [9:0]  sev;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;

  wid_dispatch u_wid_dispatch (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .global_irq_enable_instr(gen), .global_irq_disable_instr(gdis), .sleep_instr(slp),
    .core_halted(halted), .wake_pulse(wake), .vector_take(vtake), .vector_addr(vaddr),
    .src_event(sev), .conv_busy(conv_busy), .osc_run(osc), .timers_run(tmr),
    .wdt_clear(wdt), .irq(irq));

  wid_core_model u_wid_core_model (.aclk(aclk), .global_irq_enable_instr(gen),
    .global_irq_disable_instr(gdis), .sleep_instr(slp), .src_event(sev),
    .wake_pulse(wake), .vector_take(vtake), .vector_addr(vaddr), .osc_run(osc),
    .wdt_clear(wdt));

  always #20 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      final_report();
    end
  end

  task final_report;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ah, wh, bh;
    ah = 1'b0;
    wh = 1'b0;
    bh = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!(ah && wh)) begin
      @(negedge aclk);
      ah = ah || awready;
      wh = wh || wready;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    while (!bh) begin
      @(negedge aclk);
      bh = bvalid;
      r = bresp;
      @(posedge aclk);
    end
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic h;
    h = 1'b0;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    while (!h) begin
      @(negedge aclk);
      h = arready;
      @(posedge aclk);
    end
    arvalid <= 1'b0;
    h = 1'b0;
    while (!h) begin
      @(negedge aclk);
      h = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
    end
    rready <= 1'b0;
  endtask

  // Mode md: 0 sleep, 1 idle, 2 green, 3 normal
  task automatic run_case(input int src, input int md, input bit gie, input bit we, input bit ie);
    logic [31:0] d;
    logic [1:0]  r;
    logic        halt, bz, hit;
    halt = (md < 2);
    bz = (src == 5);
    hit = halt ? ((we && SLP_SET[src]) || (md == 1 && ie && IDL_SET[src])) : ie;
    do_reset();
    conv_busy <= bz;
    // Watchdog only when no wake source is enabled
    axw(wid_pkg::OFS_CTRL, {29'h0, gie && !we, md == 2, md == 1}, r);
    axw(wid_pkg::OFS_WAKE_EN, 32'(we) << src, r);
    axw(wid_pkg::OFS_IRQ_EN, 32'(ie) << src, r);
    u_wid_core_model.instr(gie ? 0 : 1);
    if (halt) begin
      u_wid_core_model.instr(2);
      `CHK(u_wid_core_model.got_wdt, gie && !we)
      `CHK(u_wid_core_model.got_osc, !(md == 0 && !bz))
      `CHK(tmr, !(md == 0 && !bz))
      `CHK(halted, 1'b1)
    end
    u_wid_core_model.fire(src);
    `CHK(u_wid_core_model.got_wake, halt && hit)
    `CHK(u_wid_core_model.got_vec, hit && gie && ie)
    if (hit && gie && ie) `CHK(u_wid_core_model.got_addr, VEC_TAB[src])
    axr(wid_pkg::OFS_STATE, d, r);
    `CHK(d[3:0], (halt && !hit) ? (md == 0 ? 4'h8 : 4'h4) : (md == 2 ? 4'h2 : 4'h1))
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    for (int s = 0; s < 10; s++) begin
      for (int m = 0; m < 4; m++) begin
        for (int c = 1; c < 8; c++) begin
          if (c != 4) run_case(s, m, c[2], c[1], c[0]);
        end
      end
    end
    do_reset();
    conv_busy <= 1'b0;
    axr(wid_pkg::OFS_STATE, d, r);
    `CHK(d[5:0], 6'h01)
    axr(8'h1c, d, r);
    `CHK({r, d}, {wid_pkg::RESP_SLVERR, 32'h0})
    axw(8'h20, 32'h1, r);
    `CHK(r, wid_pkg::RESP_SLVERR)
    axw(wid_pkg::OFS_STATE, 32'hf, r);
    axr(wid_pkg::OFS_STATE, d, r);
    `CHK(d[3:0], 4'h1)
    axw(wid_pkg::OFS_INT_MASK, 32'h1, r);
    axw(wid_pkg::OFS_WAKE_EN, 32'h1, r);
    u_wid_core_model.instr(2);
    `CHK(irq, 1'b0)
    u_wid_core_model.fire(0);
    `CHK(irq, 1'b1)
    axr(wid_pkg::OFS_INT_STAT, d, r);
    `CHK(d[3:0], 4'h5)
    axw(wid_pkg::OFS_INT_STAT, 32'h1, r);
    `CHK(irq, 1'b0)
    axw(wid_pkg::OFS_INT_MASK, 32'h4, r);
    `CHK(irq, 1'b1)
    final_report();
  end
endmodule
